// ---- rtl/spi_map.svh ----
// register offsets, field positions, reset values and counts for the serial port
`ifndef SPI_MAP_SVH
`define SPI_MAP_SVH

// register byte offsets
`define OFF_CTRL1     8'h00
`define OFF_STATUS    8'h04
`define OFF_DATA      8'h08

// status field positions and reserved mask
`define BIT_RXF       7
`define BIT_TXE       5
`define BIT_MF        4
`define STAT_ZERO     8'h4F

// control_register_one field positions
`define C_RXIE        7
`define C_EN          6
`define C_TXIE        5
`define C_MASTER_SELECT_BIT        4
`define C_SELECT_OUTPUT_ENABLE        1
`define C_FIEN        0
`define CTRL1_RST     8'h00

// synchroniser lanes
`define SY_SCK        3
`define SY_MOSI       2
`define SY_MISO       1
`define SY_SS         0

// timing
`define TX_MOVE_CYC   2
`define LAST_BIT      3'h7
`define HALF_DIV_DEF  8'h04

`endif

// ---- rtl/spi_pkg.sv ----
// state types for the serial port core and its byte shifter
package spi_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } shf_state_e;

  typedef struct packed {
    shf_state_e state;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [2:0] cnt;
    logic [7:0] div;
    logic       sck;
    logic       sck_d;
    logic       smp;
    logic       done;
  } shf_s;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [7:0] ctrl;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
    logic       tx_empty;
    logic       tx_pend;
    logic       rx_full;
    logic       fault;
    logic       arm_tx;
    logic       arm_rx;
    logic       arm_mf;
  } core_s;

endpackage

// ---- rtl/shift_if.sv ----
// carrier between the buffer core and the byte shifter
`timescale 1ns/10ps
interface shift_if;
  logic       load;
  logic [7:0] load_byte;
  logic       master;
  logic       enable;
  logic       sck_in;
  logic       mosi_in;
  logic       miso_in;
  logic       ss_n_in;
  logic       busy;
  logic       done;
  logic [7:0] rx_byte;
  logic       sck_out;
  logic       sdo;

  modport core (output load, load_byte, master, enable, sck_in, mosi_in, miso_in, ss_n_in,
                input busy, done, rx_byte, sck_out, sdo);
  modport shifter (input load, load_byte, master, enable, sck_in, mosi_in, miso_in, ss_n_in,
                   output busy, done, rx_byte, sck_out, sdo);
endinterface

// ---- rtl/byte_shifter.sv ----
// byte shifter: master clock generation or slave edge sampling, msb first
`timescale 1ns/10ps
`include "spi_map.svh"
module byte_shifter
  import spi_pkg::*;
#(
  parameter logic [7:0] HALF_DIV = `HALF_DIV_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  shift_if.shifter sif
);

  shf_s r;
  shf_s n;
  logic tick;

  ////////////////////////////////////////////////////////////////
  // half bit period divider, one-cycle enable
  assign tick = (r.div == HALF_DIV - 8'h01);

  // next state of the shifter
  always_comb begin
    n       = r;
    n.done  = 1'b0;
    n.sck_d = sif.sck_in;
    if (!sif.enable) begin
      n.state = ST_IDLE;
      n.sck   = 1'b0;
      n.cnt   = 3'h0;
    end else if (sif.master) begin
      case (r.state)
        ST_IDLE: begin
          if (sif.load) begin
            n.sh    = sif.load_byte;
            n.state = ST_RUN;
            n.cnt   = 3'h0;
            n.div   = 8'h00;
          end
        end
        ST_RUN: begin
          n.div = tick ? 8'h00 : r.div + 8'h01;
          if (tick && !r.sck) begin
            n.sck = 1'b1;
            n.smp = sif.miso_in;
          end else if (tick) begin
            n.sck = 1'b0;
            n.sh  = {r.sh[6:0], r.smp};
            n.cnt = r.cnt + 3'h1;
            if (r.cnt == `LAST_BIT) begin
              n.done  = 1'b1;
              n.rx    = {r.sh[6:0], r.smp};
              n.state = ST_IDLE;
            end
          end
        end
        default: n.state = ST_IDLE;
      endcase
    end else begin
      // slave: byte is preloaded while deselected, frame is the select low time
      if (sif.load) begin
        n.sh = sif.load_byte;
      end
      if (sif.ss_n_in) begin
        n.state = ST_IDLE;
        n.cnt   = 3'h0;
      end else begin
        n.state = ST_RUN;
        if (sif.sck_in && !r.sck_d) begin
          n.smp = sif.mosi_in;
        end else if (!sif.sck_in && r.sck_d) begin
          n.sh  = {r.sh[6:0], r.smp};
          n.cnt = r.cnt + 3'h1;
          if (r.cnt == `LAST_BIT) begin
            n.done = 1'b1;
            n.rx   = {r.sh[6:0], r.smp};
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sif.busy    = (r.state == ST_RUN);
  assign sif.done    = r.done;
  assign sif.rx_byte = r.rx;
  assign sif.sck_out = r.sck;
  assign sif.sdo     = r.sh[7];

  ////////////////////////////////////////////////////////////////
  // done is a single pulse, never held a second cycle
  chk_done_single_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    r.done |=> !r.done) else $error("shifter done held longer than one cycle");

endmodule

// ---- rtl/spi_status_data.sv ----
// serial port status and data buffers behind an apb slave
`timescale 1ns/10ps
`include "spi_map.svh"
module spi_status_data
  import spi_pkg::*;
#(
  parameter logic [7:0] HALF_DIV = `HALF_DIV_DEF
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n_in,
  output logic             ss_n_out,
  output logic             ss_n_oe
);

  localparam int MOVE_MAX = `TX_MOVE_CYC;

  core_s r;
  core_s n;
  shift_if sif ();

  logic       acc;
  logic       mapped;
  logic       rd_stat;
  logic       rd_data;
  logic       wr_ctrl;
  logic       wr_data;
  logic       clr_rx;
  logic       clr_mf;
  logic       take_wr;
  logic       do_load;
  logic       fault_mode;
  logic       en;
  logic       master_select_bit;
  logic [7:0] stat;

  ////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, unmapped address answers with error
  assign acc     = psel & penable;
  assign mapped  = (paddr == `OFF_CTRL1) | (paddr == `OFF_STATUS) | (paddr == `OFF_DATA);
  assign pready  = 1'b1;
  assign pslverr = acc & !mapped;
  assign prdata  = {24'h00_0000, r.rdata};
  assign rd_stat = acc & !pwrite & (paddr == `OFF_STATUS);
  assign rd_data = acc & !pwrite & (paddr == `OFF_DATA);
  assign wr_ctrl = acc & pwrite & (paddr == `OFF_CTRL1);
  assign wr_data = acc & pwrite & (paddr == `OFF_DATA);

  // control bits the flags depend on
  assign en   = r.ctrl[`C_EN];
  assign master_select_bit = r.ctrl[`C_MASTER_SELECT_BIT];

  // handshake qualifiers; write to status is decoded nowhere
  assign clr_rx  = rd_data & r.arm_rx & r.rx_full;
  assign clr_mf  = wr_ctrl & r.arm_mf & r.fault;
  assign take_wr = wr_data & r.arm_tx & r.tx_empty;
  assign do_load = r.tx_pend & !sif.busy & en;
  assign fault_mode = en & master_select_bit & r.ctrl[`C_FIEN] & !r.ctrl[`C_SELECT_OUTPUT_ENABLE];

  // status image, reserved positions stay zero
  always_comb begin
    stat           = 8'h00;
    stat[`BIT_RXF] = r.rx_full;
    stat[`BIT_TXE] = r.tx_empty;
    stat[`BIT_MF]  = r.fault;
  end

  ////////////////////////////////////////////////////////////////
  // next state of the core
  always_comb begin
    n     = r;
    // two flops on every pin input; only the second one is read
    n.sy1 = {sclk_in, mosi_in, miso_in, ss_n_in};
    n.sy2 = r.sy1;

    // read data captured in setup so the access phase returns a flop
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFF_CTRL1:  n.rdata = r.ctrl;
        `OFF_STATUS: n.rdata = stat;
        `OFF_DATA:   n.rdata = r.rx_buf;
        default:     n.rdata = 8'h00;
      endcase
    end

    // status read arms each clear by the value software actually saw
    if (rd_stat) begin
      n.arm_tx = r.rdata[`BIT_TXE];
      n.arm_rx = r.rdata[`BIT_RXF];
      n.arm_mf = r.rdata[`BIT_MF];
    end

    if (wr_ctrl) begin
      n.ctrl   = pwdata[7:0];
      n.arm_mf = 1'b0;
    end

    // accepted data write queues a byte; an unarmed one is dropped
    if (take_wr) begin
      n.tx_buf   = pwdata[7:0];
      n.tx_pend  = 1'b1;
      n.tx_empty = 1'b0;
      n.arm_tx   = 1'b0;
    end

    // queued byte into an idle shifter frees the buffer
    if (do_load) begin
      n.tx_pend  = 1'b0;
      n.tx_empty = 1'b1;
    end

    if (clr_rx) begin
      n.arm_rx = 1'b0;
    end

    // end of transfer: an unread old byte wins, the new byte is dropped
    // silently, there is deliberately no overrun flag
    if (sif.done && (!r.rx_full || clr_rx)) begin
      n.rx_buf = sif.rx_byte;
    end
    n.rx_full = sif.done | (r.rx_full & !clr_rx);

    // fault set beats a clear in the same cycle
    n.fault = (fault_mode & !r.sy2[`SY_SS]) | (r.fault & !clr_mf);
    if (clr_mf) begin
      n.arm_mf = 1'b0;
    end
  end

  // state register; transmit buffer starts empty
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r          <= '0;
      r.ctrl     <= `CTRL1_RST;
      r.tx_empty <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupt request, a level from flag and enable flops
  assign irq = (r.tx_empty & r.ctrl[`C_TXIE])
             | ((r.rx_full | r.fault) & r.ctrl[`C_RXIE]);

  // shifter hookup
  assign sif.load      = do_load;
  assign sif.load_byte = r.tx_buf;
  assign sif.master    = master_select_bit;
  assign sif.enable    = en;
  assign sif.sck_in    = r.sy2[`SY_SCK];
  assign sif.mosi_in   = r.sy2[`SY_MOSI];
  assign sif.miso_in   = r.sy2[`SY_MISO];
  assign sif.ss_n_in   = r.sy2[`SY_SS];

  byte_shifter #(
    .HALF_DIV (HALF_DIV)
  ) u_shifter (
    .mclk   (mclk),
    .resetn (resetn),
    .sif    (sif)
  );

  // pins: master drives clock and mosi, a selected slave drives miso
  assign sclk_out = sif.sck_out;
  assign sclk_oe  = en & master_select_bit;
  assign mosi_out = sif.sdo;
  assign mosi_oe  = en & master_select_bit;
  assign miso_out = sif.sdo;
  assign miso_oe  = en & !master_select_bit & !r.sy2[`SY_SS];
  assign ss_n_out = !sif.busy;
  assign ss_n_oe  = en & master_select_bit & r.ctrl[`C_FIEN] & r.ctrl[`C_SELECT_OUTPUT_ENABLE];

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_rx_full_set: assert property (
    sif.done |=> r.rx_full) else $error("receive-full not set after transfer end");

  chk_rx_clear_seq: assert property (
    $fell(r.rx_full) |-> $past(rd_data) && $past(r.arm_rx)) else $error("receive-full cleared without handshake");

  chk_tx_room: assert property (
    r.tx_empty |-> !r.tx_pend) else $error("transmit-empty set while a byte is queued");

  chk_tx_clear_seq: assert property (
    $fell(r.tx_empty) |-> $past(wr_data) && $past(r.arm_tx)) else $error("transmit-empty cleared without handshake");

  chk_unarmed_write: assert property (
    wr_data && !r.arm_tx |=> $stable(r.tx_buf) && !$rose(r.tx_pend)) else $error("unarmed data write was taken");

  chk_tx_irq: assert property (
    r.tx_empty && r.ctrl[`C_TXIE] |-> irq) else $error("no interrupt for transmit-empty");

  chk_idle_move: assert property (
    take_wr && !sif.busy && en && master_select_bit |-> ##[1:MOVE_MAX] (r.tx_empty && sif.busy)) else $error("idle write not moved in time");

  chk_load_sets_empty: assert property (
    sif.load |=> r.tx_empty && !r.tx_pend) else $error("move into shifter left flag clear");

  chk_fault_gate: assert property (
    !fault_mode && !r.fault |=> !r.fault) else $error("fault set outside fault input mode");

  chk_fault_clear_seq: assert property (
    $fell(r.fault) |-> $past(wr_ctrl) && $past(r.arm_mf)) else $error("fault cleared without handshake");

  chk_overrun_keep: assert property (
    sif.done && r.rx_full && !clr_rx |=> $stable(r.rx_buf)) else $error("overrun overwrote receive byte");

  chk_status_zero: assert property (
    rd_stat |-> (r.rdata & `STAT_ZERO) == 8'h00) else $error("reserved status bits not zero");

  cov_rx_byte: cover property (sif.done ##1 r.rx_full);
  cov_overrun: cover property (sif.done && r.rx_full && !clr_rx);
  cov_queue_two: cover property (take_wr ##[1:40] take_wr);
  cov_fault: cover property ($rose(r.fault));

endmodule

// ---- tb/spi_peer.sv ----
// behavioural spi slave that answers the master frames, mode 0, msb first
`timescale 1ns/10ps
module spi_peer (
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got,
  output int              frames
);
  logic [7:0] sh;
  logic [7:0] acc;
  logic       open_r;

  initial begin
    miso = 1'b0;
    got = 8'h00;
    frames = 0;
    sh = 8'h00;
    acc = 8'h00;
    open_r = 1'b0;
  end

  // first bit must stand on the line as soon as select falls
  always @(negedge ss_n) begin
    sh = reply;
    miso = reply[7];
    open_r = 1'b1;
  end

  // sample on rise, shift on fall
  always @(posedge sclk) begin
    if (!ss_n) acc = {acc[6:0], mosi};
  end
  always @(negedge sclk) begin
    if (!ss_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end

  // released line shows the inverse so a stale bit cannot pass as data
  always @(posedge ss_n) begin
    miso = ~miso;
    if (open_r) begin
      got = acc;
      frames = frames + 1;
    end
    open_r = 1'b0;
  end
endmodule

// ---- tb/spi_status_and_data_buffers_tb.sv ----
// self-checking bench for the serial port status and data buffers
`timescale 1ns/10ps
`include "spi_map.svh"
module spi_status_and_data_buffers_tb;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        sclk_out;
  logic        sclk_oe;
  logic        mosi_out;
  logic        mosi_oe;
  logic        miso_out;
  logic        miso_oe;
  logic        ss_n_out;
  logic        ss_n_oe;
  logic        tb_sclk = 1'b0;
  logic        tb_mosi = 1'b0;
  logic        tb_ss = 1'b1;
  logic        peer_miso;
  logic [7:0]  reply = 8'h5A;
  logic [7:0]  peer_got;
  logic [7:0]  bits;
  logic [31:0] rdv;
  logic        perr;
  int          frames;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // resolved pin levels, the dut's output enable picks the dut or the bench side
  wire sclk_w = sclk_oe ? sclk_out : tb_sclk;
  wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire miso_w = miso_oe ? miso_out : peer_miso;
  wire ss_w   = ss_n_oe ? ss_n_out : tb_ss;

  always #2.5 mclk = ~mclk;

  spi_status_data #(.HALF_DIV(8'h04)) dut (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe)
  );

  spi_peer peer (
    .sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .reply(reply),
    .miso(peer_miso), .got(peer_got), .frames(frames)
  );

  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, whole run needs a few hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      tally_and_finish;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // apb cycle: setup, access held until pready sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task wait_frames(input int n);
    for (int k = 0; k < 400 && frames < n; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // unarmed data write, reset view, status write, unmapped place
  task t_reset;
    wr(`OFF_CTRL1, 32'h0000_0053);
    wr(`OFF_DATA, 32'h0000_0077);
    repeat (4) @(posedge mclk);
    chk(32'(ss_w), 32'h0000_0001);
    rd(`OFF_STATUS, 32'h0000_0020);
    wr(`OFF_STATUS, 32'h0000_00FF);
    rd(`OFF_STATUS, 32'h0000_0020);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(32'(perr), 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
  endtask

  // two queued bytes, second frame overruns the unread first byte
  task t_master;
    wr(`OFF_DATA, 32'h0000_00A5);
    rd(`OFF_STATUS, 32'h0000_0020);
    chk(32'(ss_w), 32'h0000_0000);
    reply <= 8'hE1;
    wr(`OFF_DATA, 32'h0000_003C);
    rd(`OFF_STATUS, 32'h0000_0000);
    wait_frames(1);
    chk(32'(peer_got), 32'h0000_00A5);
    rd(`OFF_STATUS, 32'h0000_00A0);
    wait_frames(2);
    chk(32'(peer_got), 32'h0000_003C);
    repeat (8) @(posedge mclk);
    chk(32'(ss_w), 32'h0000_0001);
    rd(`OFF_STATUS, 32'h0000_00A0);
    rd(`OFF_DATA, 32'h0000_005A);
    rd(`OFF_STATUS, 32'h0000_0020);
  endtask

  // select pulled low by another master
  task t_fault;
    wr(`OFF_CTRL1, 32'h0000_00D1);
    tb_ss <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(`OFF_STATUS, 32'h0000_0030);
    chk(32'(irq), 32'h0000_0001);
    tb_ss <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(`OFF_CTRL1, 32'h0000_00D1);
    rd(`OFF_STATUS, 32'h0000_0020);
    chk(32'(irq), 32'h0000_0000);
    wr(`OFF_CTRL1, 32'h0000_0050);
    tb_ss <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(`OFF_STATUS, 32'h0000_0020);
    tb_ss <= 1'b1;
  endtask

  task t_irq;
    wr(`OFF_CTRL1, 32'h0000_0070);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0001);
    wr(`OFF_CTRL1, 32'h0000_0050);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // slave frame on an 80 ns link clock that stands still between frames
  task t_slave;
    logic [7:0] sent;
    sent = 8'h96;
    wr(`OFF_CTRL1, 32'h0000_0040);
    rd(`OFF_STATUS, 32'h0000_0020);
    wr(`OFF_DATA, 32'h0000_00C3);
    repeat (4) @(posedge mclk);
    tb_ss <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= sent[i];
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      bits = {bits[6:0], miso_w};
      @(posedge mclk);
      tb_sclk <= 1'b1;
      repeat (8) @(posedge mclk);
      tb_sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    tb_ss <= 1'b1;
    tb_mosi <= ~tb_mosi;
    repeat (6) @(posedge mclk);
    chk(32'(bits), 32'h0000_00C3);
    rd(`OFF_STATUS, 32'h0000_00A0);
    rd(`OFF_DATA, 32'h0000_0096);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_master;
    t_fault;
    t_irq;
    t_slave;
    tally_and_finish;
  end
endmodule
